// ===== hdl/sdlc_consts.svh
// Constants for the serial converter load and clear block
`ifndef SDLC_CONSTS_SVH
`define SDLC_CONSTS_SVH
`define SDLC_CODE_W     14
`define SDLC_WORD_W     16
`define SDLC_LEVEL_W    15
`define SDLC_CNT_W      5
`define SDLC_WORD_BITS  5'h10
`define SDLC_UNI_CLEAR  14'h0000
`define SDLC_BIP_CLEAR  14'h2000
`define SDLC_MID_LEVEL  15'h2000
`define SDLC_SYNC_N     4
`define SDLC_SYNC_SEL   0
`define SDLC_SYNC_SCLK  1
`define SDLC_SYNC_DIN   2
`define SDLC_SYNC_CLR   3
`endif

// ===== hdl/sdlc_pkg.sv
// Types for the serial converter load and clear block
`default_nettype none
`include "sdlc_consts.svh"
package sdlc_pkg;
  // Frame state, Gray coded along idle, shift, full
  typedef enum logic [1:0] {
    SDLC_IDLE  = 2'h0,
    SDLC_SHIFT = 2'h1,
    SDLC_FULL  = 2'h3
  } sdlc_state_t;

  // One received word waiting for the converter latch
  typedef struct packed {
    logic [`SDLC_CODE_W-1:0] code;
  } sdlc_entry_t;
endpackage : sdlc_pkg
`default_nettype wire

// ===== hdl/sdlc_top.sv
// Serial load and clear control for a 14-bit voltage-output converter
`timescale 1ns/1ps
`default_nettype none
`include "sdlc_consts.svh"
module sdlc_top #(
  parameter bit BIPOLAR = 1'b0
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_reset_n,
  input  wire logic                     i_sel_n,
  input  wire logic                     i_sclk,
  input  wire logic                     i_sdata,
  input  wire logic                     i_async_clear_n,
  input  wire logic                     i_latch_ready,
  output logic [`SDLC_CODE_W-1:0]       o_code_q,
  output logic [`SDLC_LEVEL_W-1:0]      o_level_q,
  output logic                          o_busy_q,
  output logic                          o_frame_err_q
);
  localparam logic [`SDLC_CODE_W-1:0] CLEAR_CODE = BIPOLAR ? `SDLC_BIP_CLEAR : `SDLC_UNI_CLEAR;
  localparam logic [`SDLC_LEVEL_W-1:0] CLEAR_LEVEL = BIPOLAR ? 15'h0000 : 15'h0000;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [`SDLC_SYNC_N-1:0] meta_q;
  logic [`SDLC_SYNC_N-1:0] sync_q;
  logic                    sclk_prev_q;
  logic                    sel_prev_q;
  logic                    sel_s;
  logic                    sclk_s;
  logic                    din_s;
  logic                    clr_s;
  logic                    sclk_rise;
  logic                    sel_rise;

  genvar gi;
  generate
    for (gi = 0; gi < `SDLC_SYNC_N; gi++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          meta_q[gi] <= 1'b1;
          sync_q[gi] <= 1'b1;
        end else begin
          meta_q[gi] <= (gi == `SDLC_SYNC_SEL) ? i_sel_n :
                        (gi == `SDLC_SYNC_SCLK) ? i_sclk :
                        (gi == `SDLC_SYNC_DIN) ? i_sdata : i_async_clear_n;
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_prev_q <= 1'b1;
      sel_prev_q  <= 1'b1;
    end else begin
      sclk_prev_q <= sync_q[`SDLC_SYNC_SCLK];
      sel_prev_q  <= sync_q[`SDLC_SYNC_SEL];
    end
  end

  assign sel_s     = sync_q[`SDLC_SYNC_SEL];
  assign sclk_s    = sync_q[`SDLC_SYNC_SCLK];
  assign din_s     = sync_q[`SDLC_SYNC_DIN];
  assign clr_s     = sync_q[`SDLC_SYNC_CLR];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sel_rise  = sel_s & ~sel_prev_q;

  // ==========================================================
  // Frame receiver
  // ==========================================================
  sdlc_pkg::sdlc_state_t   state_q, state_d;
  logic [`SDLC_WORD_W-1:0] shift_q, shift_d;
  logic [`SDLC_CNT_W-1:0]  cnt_q, cnt_d;
  logic                    err_d;
  logic                    push;
  logic                    push_ok;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    cnt_d   = cnt_q;
    err_d   = 1'b0;
    push    = 1'b0;
    if (!sel_s && sclk_rise) begin
      shift_d = {shift_q[`SDLC_WORD_W-2:0], din_s};
      if (cnt_q != `SDLC_WORD_BITS) begin
        cnt_d = cnt_q + 5'h01;
      end
    end
    if (!sel_s) begin
      state_d = (cnt_d == `SDLC_WORD_BITS) ? sdlc_pkg::SDLC_FULL : sdlc_pkg::SDLC_SHIFT;
    end
    if (sel_rise) begin
      state_d = sdlc_pkg::SDLC_IDLE;
      cnt_d   = 5'h00;
      if (state_q == sdlc_pkg::SDLC_FULL) begin
        push = 1'b1;
      end else begin
        err_d = 1'b1;
      end
    end
    // Clear also aborts a half-received frame
    if (!clr_s) begin
      state_d = sdlc_pkg::SDLC_IDLE;
      cnt_d   = 5'h00;
      push    = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q       <= sdlc_pkg::SDLC_IDLE;
      shift_q       <= 16'h0000;
      cnt_q         <= 5'h00;
      o_frame_err_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      shift_q       <= shift_d;
      cnt_q         <= cnt_d;
      o_frame_err_q <= err_d;
    end
  end

  // ==========================================================
  // Two-entry buffer
  // ==========================================================
  // The host cannot be stalled mid-word, so a push into a full
  // buffer is lost unless a pop frees a slot in the same cycle; o_busy_q warns the host ahead of that.
  sdlc_pkg::sdlc_entry_t mem_q [2];
  sdlc_pkg::sdlc_entry_t mem_d [2];
  sdlc_pkg::sdlc_entry_t head;
  logic                  wr_q, wr_d, rd_q, rd_d;
  logic [1:0]            fill_q, fill_d;
  logic                  pop;

  always_comb begin
    mem_d   = mem_q;
    wr_d    = wr_q;
    rd_d    = rd_q;
    fill_d  = fill_q;
    pop     = (fill_q != 2'h0) && i_latch_ready && clr_s;
    push_ok = push && ((fill_q != 2'h2) || pop);
    head    = mem_q[rd_q];
    if (push_ok) begin
      mem_d[wr_q].code = shift_q[`SDLC_WORD_W-1:`SDLC_WORD_W-`SDLC_CODE_W];
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    fill_d = fill_q + {1'b0, push_ok} - {1'b0, pop};
    if (!clr_s) begin
      wr_d   = 1'b0;
      rd_d   = 1'b0;
      fill_d = 2'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      fill_q   <= 2'h0;
      o_busy_q <= 1'b0;
    end else begin
      mem_q    <= mem_d;
      wr_q     <= wr_d;
      rd_q     <= rd_d;
      fill_q   <= fill_d;
      o_busy_q <= (fill_d == 2'h2);
    end
  end

  // ==========================================================
  // Converter latch
  // ==========================================================
  // Clear acts straight from the pin so it needs no clock; its
  // release is not synchronised, which is harmless as it only
  // returns the latch to holding its constant.
  logic                     latch_rst_n;
  logic [`SDLC_CODE_W-1:0]  code_d;
  logic [`SDLC_LEVEL_W-1:0] level_d;

  assign latch_rst_n = i_reset_n & i_async_clear_n;

  always_comb begin
    code_d = o_code_q;
    if (pop) begin
      code_d = head.code;
    end
    level_d = BIPOLAR ? ({1'b0, code_d} - `SDLC_MID_LEVEL) : {1'b0, code_d};
  end

  always_ff @(posedge i_clk or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      o_code_q  <= CLEAR_CODE;
      o_level_q <= CLEAR_LEVEL;
    end else begin
      o_code_q  <= code_d;
      o_level_q <= level_d;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  // Clear pulses shorter than a clock period may not show at an edge,
  // so this flop marks the edge after one for the source check
  logic clr_hit_q;

  always_ff @(posedge i_clk or negedge latch_rst_n) begin
    if (!latch_rst_n) begin
      clr_hit_q <= 1'b1;
    end else begin
      clr_hit_q <= 1'b0;
    end
  end

  AST_CLEAR_CODE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_async_clear_n |-> (o_code_q == CLEAR_CODE && o_level_q == 15'h0000))
    else $error("latch not at clear code while clear low");

  AST_POWER_ON: assert property (
    @(posedge i_clk) $rose(i_reset_n) |-> o_code_q == CLEAR_CODE)
    else $error("latch not at power-on code after reset");

  AST_LATCH_SOURCE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ($changed(o_code_q) && !clr_hit_q && $past(i_async_clear_n) && i_async_clear_n)
      |-> $past(pop) && o_code_q == $past(head.code))
    else $error("latch changed without a buffered word");

  AST_UNIPOLAR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !BIPOLAR |-> o_level_q == {1'b0, o_code_q})
    else $error("unipolar level differs from code");

  AST_BIPOLAR: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    BIPOLAR |-> o_level_q == 15'({1'b0, o_code_q} - 15'h2000))
    else $error("bipolar level not offset binary");

  AST_SAMPLE: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!sel_s && sclk_rise) |=> shift_q[0] == $past(din_s))
    else $error("data bit not sampled on clock rise");

  AST_LOAD: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (sel_rise && clr_s && state_q == sdlc_pkg::SDLC_FULL && fill_q == 2'h0
      && i_latch_ready && i_async_clear_n)
      ##1 (i_async_clear_n && clr_s && i_latch_ready) ##1 i_async_clear_n
      |-> o_code_q == $past(shift_q[15:2], 2))
    else $error("full word not loaded within two cycles of select rise");

  AST_ORDER: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    push_ok |=> mem_q[$past(wr_q)].code == $past(shift_q[15:2]))
    else $error("buffered code not first fourteen bits");

  AST_SHORT: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (sel_rise && state_q != sdlc_pkg::SDLC_FULL && !pop && clr_s)
      |=> o_frame_err_q && $stable(fill_q))
    else $error("short frame not rejected");
endmodule : sdlc_top
`default_nettype wire

// ===== sim/sdlc_host.sv
// Serial host model driving the three-wire link
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host model
module sdlc_host (
  input  wire logic i_clk,
  output logic      o_sel_n = 1'b1,
  output logic      o_sclk  = 1'b0,
  output logic      o_sdata = 1'b0
);
  // Link clock half period is four system clocks, so 160 ns
  task automatic half();
    repeat (4) @(negedge i_clk);
  endtask : half
  // MSB first, data steady across each rise
  task automatic send(input logic [15:0] w, input int n);
    @(negedge i_clk);
    o_sel_n = 1'b0;
    half();
    for (int i = 15; i > 15 - n; i--) begin
      o_sdata = w[i];
      half();
      o_sclk = 1'b1;
      half();
      o_sclk = 1'b0;
    end
    half();
    // select rises after the last fall; data no longer valid
    o_sel_n = 1'b1;
    o_sdata = ~o_sdata;
    half();
  endtask : send
endmodule : sdlc_host
`default_nettype wire

// ===== sim/sdlc_top_bench.sv
// Self-checking bench for the serial load and clear block
`timescale 1ns/1ps
`default_nettype none
// =========
// Bench top
module sdlc_top_bench;
  logic        clk, reset_n, clear_n, ready, sel_n, sclk, sdata;
  logic [13:0] code_u, code_b;
  logic [14:0] lvl_u, lvl_b;
  logic        busy_u, busy_b, ferr_u, ferr_b;
  int          errors, check_count, ferr_seen, ferr_seen_b;
  logic [13:0] tbl [4] = '{14'h3FFF, 14'h0000, 14'h2000, 14'h0001};

  sdlc_host u_sdlc_host (.i_clk(clk), .o_sel_n(sel_n), .o_sclk(sclk), .o_sdata(sdata));
  sdlc_top #(.BIPOLAR(1'b0)) u_sdlc_top (.i_clk(clk), .i_reset_n(reset_n),
    .i_sel_n(sel_n), .i_sclk(sclk), .i_sdata(sdata), .i_async_clear_n(clear_n),
    .i_latch_ready(ready), .o_code_q(code_u), .o_level_q(lvl_u), .o_busy_q(busy_u),
    .o_frame_err_q(ferr_u));
  sdlc_top #(.BIPOLAR(1'b1)) u_sdlc_top_bip (.i_clk(clk), .i_reset_n(reset_n),
    .i_sel_n(sel_n), .i_sclk(sclk), .i_sdata(sdata), .i_async_clear_n(clear_n),
    .i_latch_ready(ready), .o_code_q(code_b), .o_level_q(lvl_b), .o_busy_q(busy_b),
    .o_frame_err_q(ferr_b));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Error flag is a one-cycle pulse, so it is counted at every edge
  always @(posedge clk) if (ferr_u === 1'b1) ferr_seen++;
  always @(posedge clk) if (ferr_b === 1'b1) ferr_seen_b++;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask : chk
  task automatic load(input logic [13:0] c);
    u_sdlc_host.send({c, 2'b00}, 16);
    repeat (8) @(negedge clk);
  endtask : load
  task automatic t_load();
    foreach (tbl[i]) begin
      load(tbl[i]);
      chk("uni code", {2'b00, tbl[i]}, {2'b00, code_u});
      chk("bip code", {2'b00, tbl[i]}, {2'b00, code_b});
      chk("uni level", {2'b00, tbl[i]}, {1'b0, lvl_u});
      chk("bip level", {1'b0, 15'({1'b0, tbl[i]} - 15'h2000)}, {1'b0, lvl_b});
    end
  endtask : t_load
  task automatic t_short();
    int f0;
    int f1;
    chk("clean flag", 16'h0000, 16'(ferr_seen + ferr_seen_b));
    f0 = ferr_seen;
    f1 = ferr_seen_b;
    u_sdlc_host.send(16'hFFFF, 10);
    repeat (8) @(negedge clk);
    chk("short code", 16'h0001, {2'b00, code_u});
    chk("short flag", 16'h0001, 16'(ferr_seen - f0));
    chk("short flag bip", 16'h0001, 16'(ferr_seen_b - f1));
  endtask : t_short
  task automatic t_clear();
    load(14'h1234);
    clear_n = 1'b0;
    #1;
    chk("clr uni", 16'h0000, {2'b00, code_u});
    chk("clr bip", 16'h2000, {2'b00, code_b});
    @(negedge clk);
    clear_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("clr held", 16'h2000, {2'b00, code_b});
    chk("clr held uni", 16'h0000, {2'b00, code_u});
  endtask : t_clear
  task automatic t_stall();
    ready = 1'b0;
    load(14'h0AAA);
    load(14'h1555);
    chk("full flag", 16'h0001, {15'h0000, busy_u});
    chk("full flag bip", 16'h0001, {15'h0000, busy_b});
    chk("stalled code", 16'h0000, {2'b00, code_u});
    chk("stalled bip", 16'h2000, {2'b00, code_b});
    load(14'h3C3C);
    ready = 1'b1;
    repeat (8) @(negedge clk);
    chk("drained code", 16'h1555, {2'b00, code_u});
    chk("drained bip", 16'h1555, {2'b00, code_b});
    chk("drained flag", 16'h0000, {15'h0000, busy_u});
    chk("drained flag bip", 16'h0000, {15'h0000, busy_b});
  endtask : t_stall
  task automatic summarize();
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    reset_n = 1'b0;
    clear_n = 1'b1;
    ready = 1'b1;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset uni", 16'h0000, {2'b00, code_u});
    chk("reset bip", 16'h2000, {2'b00, code_b});
    t_load();
    t_short();
    t_clear();
    t_stall();
    summarize();
  end
  // Nine frames take about 1300 clocks; the limit leaves ample margin
  initial begin
    #400000;
    errors++;
    summarize();
  end
endmodule : sdlc_top_bench
`default_nettype wire
